// File: logic/ccr_ctrl.sv
`timescale 1ns/1ps
module ccr_ctrl
(
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // source status and mode
  input  wire logic                 pll_locked,
  input  wire logic                 fabric_clock_valid,
  input  wire logic                 backup_write_unlock,
  input  wire logic                 backup_domain_reset,
  input  wire ccr_pkg::ccr_pmode_t  power_mode,
  input  wire ccr_pkg::ccr_rst_src_t rst_src,
  // clock control outputs
  output ccr_pkg::ccr_osc_t         osc_ctl,
  output ccr_pkg::ccr_src_t         system_clock_select,
  output logic                      fast_osc_release,
  output logic                      slow_crystal_release,
  output logic                      internal_slow_tick,
  output logic      [1:0]           calendar_clock_select,
  output logic                      indep_watchdog_clock_select,
  // reset outputs
  output logic                      sys_reset_n,
  output logic                      enter_standby,
  output logic                      enter_stop
);
  import ccr_pkg::*;

  // apb state
  logic        pready_reg, pready_next;
  logic        perr_reg, perr_next;
  logic [31:0] prdata_reg, prdata_next;

  // clock state
  logic     int_en_reg, int_en_next;
  logic     fast_en_reg, fast_en_next;
  logic     fast_byp_reg, fast_byp_next;
  logic     pll_en_reg, pll_en_next;
  ccr_src_t sel_reg, sel_next;
  ccr_src_t req_reg, req_next;
  logic     fast_rel_reg, fast_rel_next;
  logic     slow_rel_reg, slow_rel_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic     tick_reg, tick_next;

  // backup domain state
  logic       slow_en_reg, slow_en_next;
  logic       wsel_reg, wsel_next;
  logic [1:0] cal_reg, cal_next;
  logic       lock_reg, lock_next;
  logic       wdog_reg, wdog_next;

  // reset state
  ccr_rstate_t      rs_reg, rs_next;
  logic [HOLD_W-1:0] hold_reg, hold_next;
  ccr_rst_flags_t   flags_reg, flags_next;
  logic [1:0]       opt_reg, opt_next;
  logic             srst_reg, srst_next;
  logic             stdby_reg, stdby_next;
  logic             stop_reg, stop_next;

  logic int_rdy, fast_rdy, slow_rdy, pll_rdy;
  logic acc, setup, bd_clear;
  logic lp_rst, any_rst;
  ccr_rst_flags_t ev;

  function automatic logic wr_hit(input logic [11:0] off);
    wr_hit = acc && pwrite && (paddr == off);
  endfunction : wr_hit

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == OFF_CLK_CTRL) || (a == OFF_CLK_CFG) ||
                 (a == OFF_BKP_CTRL) || (a == OFF_RST_STAT) ||
                 (a == OFF_OPTION);
  endfunction : addr_known

  // a source is busy when it feeds the system clock itself or via pll
  function automatic logic src_busy(input ccr_src_t sel,
                                    input ccr_src_t src);
    src_busy = (sel == src) ||
               (src == SRC_EXT_FAST && sel == SRC_PLL);
  endfunction : src_busy

  ccr_startup #(.START_CYC(INT_FAST_START_CYC)) u_int_start
  (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (int_en_reg),
    .ready   (int_rdy)
  );

  ccr_startup #(.START_CYC(FAST_START_CYC)) u_fast_start
  (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (fast_en_reg),
    .ready   (fast_rdy)
  );

  ccr_startup #(.START_CYC(SLOW_START_CYC)) u_slow_start
  (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (slow_en_reg),
    .ready   (slow_rdy)
  );

  // the pll multiplies the external fast oscillator
  assign pll_rdy  = pll_en_reg && pll_locked && fast_rdy;
  assign setup    = psel && !penable;
  assign acc      = psel && penable && pready_reg;
  assign bd_clear = backup_domain_reset ||
                    (wr_hit(OFF_BKP_CTRL) && backup_write_unlock &&
                     pwdata[B_BD_RESET]);

  // apb: no wait state, read data sampled in the setup cycle
  always_comb
  begin
    pready_next = setup;
    perr_next   = setup && !addr_known(paddr);
    prdata_next = prdata_reg;
    if (setup)
    begin
      prdata_next = 32'h0000_0000;
      case (paddr)
        OFF_CLK_CTRL:
        begin
          prdata_next[B_INT_EN]   = int_en_reg;
          prdata_next[B_INT_RDY]  = int_rdy;
          prdata_next[B_FAST_EN]  = fast_en_reg;
          prdata_next[B_FAST_RDY] = fast_rdy;
          prdata_next[B_FAST_BYP] = fast_byp_reg;
          prdata_next[B_PLL_EN]   = pll_en_reg;
          prdata_next[B_PLL_RDY]  = pll_rdy;
        end
        OFF_CLK_CFG:
        begin
          prdata_next[B_SW_REQ+:2]  = req_reg;
          prdata_next[B_SW_STAT+:2] = sel_reg;
        end
        OFF_BKP_CTRL:
        begin
          prdata_next[B_SLOW_EN]    = slow_en_reg;
          prdata_next[B_SLOW_RDY]   = slow_rdy;
          prdata_next[B_WDOG_SEL]   = wsel_reg;
          prdata_next[B_CAL_SEL+:2] = cal_reg;
          prdata_next[B_CAL_LOCK]   = lock_reg;
        end
        OFF_RST_STAT: prdata_next[B_FLAGS+:5] = flags_reg;
        OFF_OPTION:   prdata_next[1:0] = opt_reg;
        default:      prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      perr_reg   <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= pready_next;
      perr_reg   <= perr_next;
      prdata_reg <= prdata_next;
    end
  end

  // clock sources and system clock switch
  always_comb
  begin
    int_en_next   = int_en_reg;
    fast_en_next  = fast_en_reg;
    fast_byp_next = fast_byp_reg;
    pll_en_next   = pll_en_reg;
    sel_next      = sel_reg;
    req_next      = req_reg;
    if (srst_reg)
    begin
      // the external fast oscillator and pll stop with the system clock back home
      int_en_next   = 1'b1;
      fast_en_next  = 1'b0;
      fast_byp_next = 1'b0;
      pll_en_next   = 1'b0;
      sel_next      = SRC_INT_FAST;
      req_next      = SRC_INT_FAST;
    end
    else
    begin
      if (wr_hit(OFF_CLK_CTRL))
      begin
        // each enable is written alone, a busy source stays on
        int_en_next  = pwdata[B_INT_EN] ||
                       src_busy(sel_reg, SRC_INT_FAST);
        fast_en_next = pwdata[B_FAST_EN] ||
                       src_busy(sel_reg, SRC_EXT_FAST);
        pll_en_next  = pwdata[B_PLL_EN] ||
                       src_busy(sel_reg, SRC_PLL);
        // a write changes bypass only while the oscillator is off
        if (!fast_en_reg)
          fast_byp_next = pwdata[B_FAST_BYP];
      end
      if (wr_hit(OFF_CLK_CFG))
        req_next = ccr_src_t'(pwdata[B_SW_REQ+:2]);
      case (req_reg)
        SRC_INT_FAST: if (int_rdy) sel_next = req_reg;
        SRC_EXT_FAST: if (fast_rdy) sel_next = req_reg;
        SRC_PLL:      if (pll_rdy) sel_next = req_reg;
        SRC_FABRIC:   if (fabric_clock_valid) sel_next = req_reg;
        default:      sel_next = sel_reg;
      endcase
    end
    fast_rel_next = fast_en_reg && fast_rdy;
    slow_rel_next = slow_en_reg && slow_rdy;
    // free-running from the internal oscillator, so stop mode keeps it
    div_next  = int_rdy ? div_reg + DIV_W'(1) : div_reg;
    tick_next = int_rdy && (div_reg == DIV_W'(SLOW_DIV - 1));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_en_reg   <= 1'b1;
      fast_en_reg  <= 1'b0;
      fast_byp_reg <= 1'b0;
      pll_en_reg   <= 1'b0;
      sel_reg      <= SRC_INT_FAST;
      req_reg      <= SRC_INT_FAST;
      fast_rel_reg <= 1'b0;
      slow_rel_reg <= 1'b0;
      div_reg      <= '0;
      tick_reg     <= 1'b0;
    end
    else
    begin
      int_en_reg   <= int_en_next;
      fast_en_reg  <= fast_en_next;
      fast_byp_reg <= fast_byp_next;
      pll_en_reg   <= pll_en_next;
      sel_reg      <= sel_next;
      req_reg      <= req_next;
      fast_rel_reg <= fast_rel_next;
      slow_rel_reg <= slow_rel_next;
      div_reg      <= div_next;
      tick_reg     <= tick_next;
    end
  end

  // backup domain: untouched by system reset
  always_comb
  begin
    slow_en_next = slow_en_reg;
    wsel_next    = wsel_reg;
    cal_next     = cal_reg;
    lock_next    = lock_reg;
    if (bd_clear)
    begin
      slow_en_next = 1'b0;
      wsel_next    = WDOG_RST;
      cal_next     = CAL_NONE;
      lock_next    = 1'b0;
    end
    else if (wr_hit(OFF_BKP_CTRL) && backup_write_unlock)
    begin
      slow_en_next = pwdata[B_SLOW_EN];
      wsel_next    = pwdata[B_WDOG_SEL];
      // first nonzero selection sticks
      if (!lock_reg)
      begin
        cal_next  = pwdata[B_CAL_SEL+:2];
        lock_next = pwdata[B_CAL_SEL+:2] != CAL_NONE;
      end
    end
    // standby overrides the software choice
    wdog_next = (power_mode == PM_STANDBY) ? WDOG_SLOW_XTAL
                                           : wsel_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_en_reg <= 1'b0;
      wsel_reg    <= WDOG_RST;
      cal_reg     <= CAL_NONE;
      lock_reg    <= 1'b0;
      wdog_reg    <= WDOG_RST;
    end
    else
    begin
      slow_en_reg <= slow_en_next;
      wsel_reg    <= wsel_next;
      cal_reg     <= cal_next;
      lock_reg    <= lock_next;
      wdog_reg    <= wdog_next;
    end
  end

  // system reset sequencer and cause flags
  assign lp_rst = (rst_src.standby_entry && !opt_reg[B_OPT_STDBY]) ||
                  (rst_src.stop_entry && !opt_reg[B_OPT_STOP]);
  assign ev.pin_low  = rst_src.pin_low;
  assign ev.sw_req   = rst_src.sw_reset_request;
  assign ev.indep_watchdog_end  = rst_src.indep_watchdog_end;
  assign ev.window_watchdog_end = rst_src.window_watchdog_end;
  assign ev.lowpower = lp_rst;
  assign any_rst = |ev;

  always_comb
  begin
    rs_next    = rs_reg;
    hold_next  = hold_reg;
    opt_next   = opt_reg;
    flags_next = flags_reg;
    // a clear in the same cycle as an event loses
    if (wr_hit(OFF_RST_STAT) && pwdata[B_CLR_FLAGS])
      flags_next = '0;
    flags_next = flags_next | ev;
    if (wr_hit(OFF_OPTION))
    begin
      opt_next[B_OPT_STDBY] = pwdata[B_OPT_STDBY];
      opt_next[B_OPT_STOP]  = pwdata[B_OPT_STOP];
    end
    case (rs_reg)
      RS_RUN:
        if (any_rst)
        begin
          rs_next   = RS_HOLD;
          hold_next = '0;
        end
      RS_HOLD:
        // a pin held low stretches the reset for as long as it stays low
        if (any_rst)
          hold_next = '0;
        else if (hold_reg == HOLD_W'(RST_HOLD_CYC - 1))
          rs_next = RS_RUN;
        else
          hold_next = hold_reg + HOLD_W'(1);
      default: rs_next = RS_RUN;
    endcase
    srst_next  = rs_next == RS_HOLD;
    // entry goes ahead only when the option bit is set
    stdby_next = rst_src.standby_entry && opt_reg[B_OPT_STDBY];
    stop_next  = rst_src.stop_entry && opt_reg[B_OPT_STOP];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rs_reg    <= RS_RUN;
      hold_reg  <= '0;
      opt_reg   <= OPT_RST;
      flags_reg <= '0;
      srst_reg  <= 1'b0;
      stdby_reg <= 1'b0;
      stop_reg  <= 1'b0;
    end
    else
    begin
      rs_reg    <= rs_next;
      hold_reg  <= hold_next;
      opt_reg   <= opt_next;
      flags_reg <= flags_next;
      srst_reg  <= srst_next;
      stdby_reg <= stdby_next;
      stop_reg  <= stop_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = perr_reg;

  assign osc_ctl.internal_fast_osc   = int_en_reg;
  assign osc_ctl.fast_osc_enable     = fast_en_reg;
  assign osc_ctl.fast_osc_bypass     = fast_byp_reg;
  assign osc_ctl.pll_enable          = pll_en_reg;
  assign osc_ctl.slow_crystal_enable = slow_en_reg;

  assign system_clock_select         = sel_reg;
  assign fast_osc_release            = fast_rel_reg;
  assign slow_crystal_release        = slow_rel_reg;
  assign internal_slow_tick          = tick_reg;
  assign calendar_clock_select       = cal_reg;
  assign indep_watchdog_clock_select = wdog_reg;
  assign sys_reset_n                 = !srst_reg;
  assign enter_standby               = stdby_reg;
  assign enter_stop                  = stop_reg;

endmodule : ccr_ctrl

// File: logic/ccr_pkg.sv
package ccr_pkg;

  // apb geometry
  localparam int unsigned AW = 12;
  localparam int unsigned DW = 32;

  // register byte offsets
  localparam logic [11:0] OFF_CLK_CTRL = 12'h000;
  localparam logic [11:0] OFF_CLK_CFG  = 12'h004;
  localparam logic [11:0] OFF_BKP_CTRL = 12'h008;
  localparam logic [11:0] OFF_RST_STAT = 12'h00c;
  localparam logic [11:0] OFF_OPTION   = 12'h010;

  // clock_control_reg fields
  localparam int unsigned B_INT_EN   = 0;
  localparam int unsigned B_INT_RDY  = 1;
  localparam int unsigned B_FAST_EN  = 16;
  localparam int unsigned B_FAST_RDY = 17;
  localparam int unsigned B_FAST_BYP = 18;
  localparam int unsigned B_PLL_EN   = 24;
  localparam int unsigned B_PLL_RDY  = 25;

  // clock configuration fields: request [1:0], status [3:2]
  localparam int unsigned B_SW_REQ  = 0;
  localparam int unsigned B_SW_STAT = 2;

  // backup_domain_ctrl_reg fields
  localparam int unsigned B_SLOW_EN  = 0;
  localparam int unsigned B_SLOW_RDY = 1;
  localparam int unsigned B_WDOG_SEL = 2;
  localparam int unsigned B_CAL_SEL  = 8;
  localparam int unsigned B_CAL_LOCK = 15;
  localparam int unsigned B_BD_RESET = 16;

  // reset_status_reg fields
  localparam int unsigned B_CLR_FLAGS = 24;
  localparam int unsigned B_FLAGS     = 26;

  // option fields, both set after power-up
  localparam int unsigned B_OPT_STDBY = 0;
  localparam int unsigned B_OPT_STOP  = 1;
  localparam logic [1:0]  OPT_RST     = 2'h3;

  // calendar clock select encodings
  localparam logic [1:0] CAL_NONE      = 2'h0;
  localparam logic [1:0] CAL_SLOW_XTAL = 2'h1;
  localparam logic [1:0] CAL_INT_SLOW  = 2'h2;
  localparam logic [1:0] CAL_FABRIC    = 2'h3;

  // watchdog clock select: 1 slow crystal, 0 internal slow clock
  localparam logic WDOG_SLOW_XTAL = 1'b1;
  localparam logic WDOG_RST       = 1'b0;

  // cycle counts at 200 MHz
  localparam int unsigned INT_FAST_START_CYC = 64;
  localparam int unsigned FAST_START_CYC     = 2048;
  localparam int unsigned SLOW_START_CYC     = 4096;
  localparam int unsigned START_W            = 13;
  localparam int unsigned SLOW_DIV           = 256;
  localparam int unsigned DIV_W              = 8;
  localparam int unsigned RST_HOLD_CYC       = 16;
  localparam int unsigned HOLD_W             = 5;

  typedef enum logic [1:0] {
    SRC_INT_FAST,
    SRC_EXT_FAST,
    SRC_PLL,
    SRC_FABRIC
  } ccr_src_t;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_STOP,
    PM_STANDBY
  } ccr_pmode_t;

  typedef enum logic {
    RS_RUN,
    RS_HOLD
  } ccr_rstate_t;

  // reset events, flag order is the bit order in the status register
  typedef struct packed {
    logic lowpower;
    logic window_watchdog_end;
    logic indep_watchdog_end;
    logic sw_req;
    logic pin_low;
  } ccr_rst_flags_t;

  typedef struct packed {
    logic pin_low;
    logic window_watchdog_end;
    logic indep_watchdog_end;
    logic sw_reset_request;
    logic standby_entry;
    logic stop_entry;
  } ccr_rst_src_t;

  typedef struct packed {
    logic internal_fast_osc;
    logic fast_osc_enable;
    logic fast_osc_bypass;
    logic pll_enable;
    logic slow_crystal_enable;
  } ccr_osc_t;

endpackage : ccr_pkg

// File: logic/ccr_startup.sv
`timescale 1ns/1ps
module ccr_startup
#(
  parameter int unsigned START_CYC = 64
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // source control
  input  wire logic enable,
  output logic      ready
);
  import ccr_pkg::*;

  logic [START_W-1:0] cnt_reg;
  logic [START_W-1:0] cnt_next;
  logic               rdy_reg;
  logic               rdy_next;

  // ready drops at once when the source is turned off
  always_comb
  begin
    cnt_next = cnt_reg;
    rdy_next = rdy_reg;
    if (!enable)
    begin
      cnt_next = '0;
      rdy_next = 1'b0;
    end
    else if (!rdy_reg)
    begin
      if (cnt_reg == START_W'(START_CYC - 1))
        rdy_next = 1'b1;
      else
        cnt_next = cnt_reg + START_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end

  assign ready = rdy_reg;

endmodule : ccr_startup

// File: test/ccr_ctrl_checker.sv
`timescale 1ns/1ps
module ccr_ctrl_checker
(
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pready,
  // sources and modes
  input wire logic                  pll_locked,
  input wire ccr_pkg::ccr_pmode_t   power_mode,
  input wire ccr_pkg::ccr_rst_src_t rst_src,
  // outputs watched
  input wire ccr_pkg::ccr_osc_t     osc_ctl,
  input wire ccr_pkg::ccr_src_t     system_clock_select,
  input wire logic                  fast_osc_release,
  input wire logic                  slow_crystal_release,
  input wire logic                  internal_slow_tick,
  input wire logic                  indep_watchdog_clock_select,
  input wire logic                  sys_reset_n,
  input wire logic                  enter_stop
);
  import ccr_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rst_fall;
    $fell(sys_reset_n);
  endsequence

  AST_APB_ANSWER: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  // a system reset may restart the internal oscillator that drives the divider, so it aborts the attempt
  AST_SLOW_TICK: assert property (
    disable iff (!presetn || !sys_reset_n)
    internal_slow_tick |-> ##256 internal_slow_tick)
    else $error("slow tick period wrong");
  AST_FAST_GATE: assert property (fast_osc_release |->
    $past(osc_ctl.fast_osc_enable)) else $error("fast released while off");
  AST_SLOW_GATE: assert property (slow_crystal_release |->
    $past(osc_ctl.slow_crystal_enable)) else $error("slow released while off");
  AST_RST_EVENT: assert property (
    (rst_src.pin_low || rst_src.window_watchdog_end ||
     rst_src.indep_watchdog_end || rst_src.sw_reset_request)
    |=> !sys_reset_n) else $error("reset event ignored");
  AST_RST_HOLD: assert property (s_rst_fall |-> (!sys_reset_n)[*8])
    else $error("system reset too short");
  AST_RST_CLK: assert property (s_rst_fall |=>
    system_clock_select == SRC_INT_FAST) else $error("reset kept source");
  AST_EXT_IN_USE: assert property (
    system_clock_select == SRC_EXT_FAST |-> osc_ctl.fast_osc_enable)
    else $error("used source stopped");
  AST_PLL_SWITCH: assert property (($changed(system_clock_select) &&
    system_clock_select == SRC_PLL) |-> $past(pll_locked))
    else $error("switch to unlocked pll");
  AST_STBY_WDOG: assert property (power_mode == PM_STANDBY |=>
    indep_watchdog_clock_select) else $error("standby watchdog clock");
  AST_STOP_PULSE: assert property (enter_stop |->
    $past(rst_src.stop_entry)) else $error("stop entry without cause");
endmodule : ccr_ctrl_checker

bind ccr_ctrl ccr_ctrl_checker chk_u (.*);

// File: test/ccr_far_model.sv
`timescale 1ns/1ps
module ccr_far_model
#(
  parameter int unsigned LOCK_CYC = 20
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pll and reset pin
  input  wire logic pll_enable,
  input  wire logic pin_req,
  output logic      pll_locked,
  output logic      pin_low
);
  int unsigned cnt_reg;
  // lock is lost at once when the pll is switched off
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_reg <= 0;
      pin_low <= 1'b0;
    end
    else
    begin
      if (!pll_enable)
        cnt_reg <= 0;
      else if (cnt_reg < LOCK_CYC)
        cnt_reg <= cnt_reg + 1;
      pin_low <= pin_req;
    end
  assign pll_locked = (cnt_reg >= LOCK_CYC);
endmodule : ccr_far_model

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ccr_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, fab_ok, unlock, bd_rst;
  logic pin_req, pin_low, pll_lk, pready, pslverr, er, ent;
  logic frel, srel, tick, wsel, srst_n, e_stby, e_stop;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  ev;
  logic [1:0]  cal;
  ccr_pmode_t  pmode;
  ccr_osc_t    osc;
  ccr_src_t    sel;
  int          num_errors = 0;
  int          n_checks = 0;
  int          lo;

  ccr_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pll_locked(pll_lk), .fabric_clock_valid(fab_ok),
    .backup_write_unlock(unlock), .backup_domain_reset(bd_rst),
    .power_mode(pmode), .rst_src({pin_low, ev}), .osc_ctl(osc),
    .system_clock_select(sel), .fast_osc_release(frel),
    .slow_crystal_release(srel), .internal_slow_tick(tick),
    .calendar_clock_select(cal), .indep_watchdog_clock_select(wsel),
    .sys_reset_n(srst_n), .enter_standby(e_stby), .enter_stop(e_stop));
  ccr_far_model far_u (.pclk(pclk), .presetn(presetn),
    .pll_enable(osc.pll_enable), .pin_req(pin_req),
    .pll_locked(pll_lk), .pin_low(pin_low));

  task finish_test;
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      num_errors++;
      $display("[FAIL] %0t apb timeout", $time);
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task poll(input logic [11:0] a, input int b, input logic v);
    int i;
    i = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      i++;
    end while (rd[b] !== v && i < 2000);
    if (i >= 2000)
    begin
      num_errors++;
      $display("[FAIL] %0t poll timeout", $time);
      finish_test();
    end
  endtask : poll

  task settle;
    repeat (3) @(negedge pclk);
  endtask : settle

  // one event input pulsed for a cycle, then 40 cycles watched
  task fire(input int b);
    @(posedge pclk);
    if (b == 5) pin_req <= 1'b1;
    else ev[b] <= 1'b1;
    @(posedge pclk);
    pin_req <= 1'b0; ev <= 5'h0; lo = 0; ent = 1'b0;
    repeat (40)
    begin
      @(posedge pclk);
      if (srst_n === 1'b0) lo++;
      if (e_stop === 1'b1 || e_stby === 1'b1) ent = 1'b1;
    end
  endtask : fire

  task t_boot;
    apb(1'b0, OFF_CLK_CFG, 32'h0);
    chk(rd, 32'h0, "boot source");
    chk(osc.internal_fast_osc, 1'b1, "int osc on");
    apb(1'b0, OFF_OPTION, 32'h0); chk(rd[1:0], OPT_RST, "options");
    apb(1'b0, 12'h014, 32'h0); chk(er, 1'b1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    poll(OFF_CLK_CTRL, B_INT_RDY, 1'b1);
    // any window of two periods holds exactly two ticks
    lo = 0;
    repeat (2 * SLOW_DIV)
    begin
      @(posedge pclk);
      if (tick === 1'b1) lo++;
    end
    chk(lo, 32'd2, "slow ticks");
  endtask : t_boot

  task t_system_clock;
    apb(1'b1, OFF_CLK_CTRL, 32'h0001_0001); settle;
    chk(frel, 1'b0, "fast gated");
    poll(OFF_CLK_CTRL, B_FAST_RDY, 1'b1); settle;
    chk(frel, 1'b1, "fast released");
    apb(1'b1, OFF_CLK_CFG, 32'h1); poll(OFF_CLK_CFG, B_SW_STAT, 1'b1);
    chk(sel, SRC_EXT_FAST, "to fast");
    apb(1'b1, OFF_CLK_CTRL, 32'h1); apb(1'b0, OFF_CLK_CTRL, 32'h0);
    chk(rd[B_FAST_EN], 1'b1, "stop in use");
    apb(1'b1, OFF_CLK_CTRL, 32'h0101_0001); apb(1'b1, OFF_CLK_CFG, 32'h2);
    apb(1'b0, OFF_CLK_CFG, 32'h0);
    chk(rd[3:2], 2'h1, "pll not locked");
    poll(OFF_CLK_CFG, 3, 1'b1); chk(rd[3:2], 2'h2, "to pll");
    apb(1'b1, OFF_CLK_CTRL, 32'h1); settle;
    chk(osc.fast_osc_enable, 1'b1, "pll feed kept");
    apb(1'b1, OFF_CLK_CFG, 32'h3); settle;
    chk(sel, SRC_PLL, "fabric not ready");
    @(posedge pclk);
    fab_ok <= 1'b1;
    poll(OFF_CLK_CFG, 2, 1'b1); chk(sel, SRC_FABRIC, "to fabric");
    apb(1'b1, OFF_CLK_CTRL, 32'h1); settle;
    chk(osc.fast_osc_enable, 1'b0, "fast off");
    chk(osc.pll_enable, 1'b0, "pll off");
    apb(1'b1, OFF_CLK_CFG, 32'h0); poll(OFF_CLK_CFG, 2, 1'b0);
  endtask : t_system_clock

  task t_backup;
    apb(1'b1, OFF_BKP_CTRL, 32'h1); apb(1'b0, OFF_BKP_CTRL, 32'h0);
    chk(rd[B_SLOW_EN], 1'b0, "protected");
    unlock <= 1'b1;
    apb(1'b1, OFF_BKP_CTRL, 32'h0101); settle;
    chk(cal, CAL_SLOW_XTAL, "cal select");
    chk(srel, 1'b0, "slow gated");
    apb(1'b1, OFF_BKP_CTRL, 32'h0205); settle;
    chk(cal, CAL_SLOW_XTAL, "cal locked");
    chk(wsel, WDOG_SLOW_XTAL, "wdog crystal");
    poll(OFF_BKP_CTRL, B_SLOW_RDY, 1'b1); settle;
    chk(srel, 1'b1, "slow released");
    apb(1'b1, OFF_BKP_CTRL, 32'h1); settle;
    chk(wsel, 1'b0, "wdog internal");
    @(posedge pclk);
    pmode <= PM_STANDBY;
    settle; chk(wsel, 1'b1, "standby wdog");
    @(posedge pclk);
    pmode <= PM_RUN;
    apb(1'b1, OFF_BKP_CTRL, 32'h0001_0000); apb(1'b1, OFF_BKP_CTRL, 32'h0300);
    settle; chk(cal, CAL_FABRIC, "relock");
    @(posedge pclk);
    bd_rst <= 1'b1;
    @(posedge pclk);
    bd_rst <= 1'b0;
    settle; chk(cal, CAL_NONE, "backup reset");
  endtask : t_backup

  task t_resets;
    int src [4] = '{5, 2, 3, 4};
    logic [1:0] opt [4] = '{2'h2, 2'h2, 2'h1, 2'h1};
    logic rsp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    apb(1'b1, OFF_CLK_CTRL, 32'h0005_0001);
    apb(1'b1, OFF_CLK_CTRL, 32'h0001_0001);
    poll(OFF_CLK_CTRL, B_FAST_RDY, 1'b1);
    chk(osc.fast_osc_bypass, 1'b1, "bypass kept");
    apb(1'b1, OFF_CLK_CFG, 32'h1); poll(OFF_CLK_CFG, B_SW_STAT, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      fire(src[k]);
      chk(lo >= 16 && lo <= 18, 1'b1, "reset hold");
      if (k == 0) chk(sel, SRC_INT_FAST, "reset source");
      if (k == 0) chk(osc.fast_osc_bypass, 1'b0, "bypass reset");
      apb(1'b0, OFF_RST_STAT, 32'h0);
      chk(rd[30:26], 5'h1 << k, "cause flag");
      apb(1'b1, OFF_RST_STAT, 32'h0100_0000); apb(1'b0, OFF_RST_STAT, 32'h0);
      chk(rd[30:26], 5'h0, "flags cleared");
    end
    // each option with each entry kind
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, OFF_OPTION, {30'h0, opt[k]}); fire(k % 2);
      chk(lo > 0, rsp[k], "low power reset");
      chk(ent, !rsp[k], "mode entry");
      apb(1'b0, OFF_RST_STAT, 32'h0);
      chk(rd[30], rsp[k], "lp flag");
      apb(1'b1, OFF_RST_STAT, 32'h0100_0000);
    end
  endtask : t_resets

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h0; pwdata = 32'h0; fab_ok = 1'b0; unlock = 1'b0;
    bd_rst = 1'b0; pin_req = 1'b0; ev = 5'h0; pmode = PM_RUN;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_boot;
    t_system_clock;
    t_backup;
    t_resets;
    finish_test();
  end
endmodule : testbench
